// file: design/esq_map.svh
// Register map, field positions, reset values and timing counts of the exposure sequencer
`ifndef ESQ_MAP_SVH
`define ESQ_MAP_SVH

// Clock rate
`define ESQ_CLK_MHZ       125

// Register byte offsets
`define ESQ_CTRL_OFS      8'h00
`define ESQ_SHUT_OFS      8'h04
`define ESQ_ROI_OFS       8'h08
`define ESQ_PKT_OFS       8'h0c
`define ESQ_OSEL_OFS      8'h10
`define ESQ_STAT_OFS      8'h14
`define ESQ_FCNT_OFS      8'h18

// Control register fields
`define ESQ_CTRL_EN_BIT   0
`define ESQ_CTRL_POL_BIT  1
`define ESQ_CTRL_LVL_BIT  2
`define ESQ_CTRL_COL_BIT  3

// Output routing fields (2-bit port numbers)
`define ESQ_OSEL_SAFE_LSB 0
`define ESQ_OSEL_ACT_LSB  2

// Reset values
`define ESQ_CTRL_RST      4'h3
`define ESQ_SHUT_RST      20'h003e8
`define ESQ_ROI_RST       11'h410
`define ESQ_PKT_RST       16'h0040
`define ESQ_OSEL_RST      4'h1

// Durations in hundredths of a microsecond
`define ESQ_ROW_T         4456
`define ESQ_CMONO_T       702911
`define ESQ_CCOL_T        707367
`define ESQ_BUS_T         12500
`define ESQ_TO_CY(t)      ((((t) * `ESQ_CLK_MHZ) + 50) / 100)

// Exposure-active output delays in microseconds (least times)
`define ESQ_ACT_ON_US     5
`define ESQ_ACT_OFF_US    30
`define ESQ_ACT_ON_CY     (`ESQ_ACT_ON_US * `ESQ_CLK_MHZ)
`define ESQ_ACT_OFF_CY    (`ESQ_ACT_OFF_US * `ESQ_CLK_MHZ)

// AXI responses
`define ESQ_RESP_OKAY     2'b00
`define ESQ_RESP_DECERR   2'b11

`endif

// file: design/esq_pkg.sv
// Types shared by the exposure sequencer modules
`default_nettype none
package esq_pkg;

   typedef logic [7:0]  esq_addr_type;
   typedef logic [31:0] esq_word_type;

   typedef enum logic {EXP_IDLE, EXP_ON} esq_exp_type;

   typedef enum logic [2:0] {
      REG_CTRL, REG_SHUT, REG_ROI, REG_PKT, REG_OSEL, REG_STAT, REG_FCNT, REG_NONE
   } esq_reg_type;

   // Timing calculator state
   typedef struct packed {
      logic [31:0] ro_cy;
      logic [31:0] tx_cy;
      logic [31:0] dly_cy;
      logic [31:0] shut_cy;
      logic [31:0] gap_cy;
   } esq_calc_type;

   // Sequencer state
   typedef struct packed {
      logic        trig_d;
      esq_exp_type exp_st;
      logic [31:0] exp_cnt;
      logic        safe;
      logic        gap_run;
      logic [31:0] gap_cnt;
      logic        ro_busy;
      logic        ro_pend;
      logic [31:0] ro_cnt;
      logic        txd_run;
      logic [31:0] txd_cnt;
      logic [31:0] dly_l;
      logic        tx_busy;
      logic        tx_start;
      logic [31:0] tx_cnt;
      logic        act;
      logic        on_run;
      logic [11:0] on_cnt;
      logic        off_run;
      logic [11:0] off_cnt;
      logic [31:0] period;
      logic [31:0] last_exp;
      logic        ovl;
      logic [15:0] frames;
      logic        aw_v;
      logic [7:0]  awaddr;
      logic        w_v;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [3:0]  ctrl;
      logic [19:0] shutter;
      logic [10:0] height;
      logic [15:0] packets;
      logic [3:0]  osel;
      logic [15:0] since_start;
      logic [15:0] since_end;
      logic [31:0] since_ro;
   } esq_state_type;

endpackage
`default_nettype wire

// file: design/esq_calc_if.sv
// Configuration and derived timing between sequencer and timing calculator
`timescale 1ns/1ns
`default_nettype none
interface esq_calc_if;
   logic        colour;
   logic [10:0] height;
   logic [15:0] packets;
   logic [19:0] shutter;
   logic [31:0] ro_cy;
   logic [31:0] tx_cy;
   logic [31:0] dly_cy;
   logic [31:0] shut_cy;
   logic [31:0] gap_cy;

   modport calc (input colour, height, packets, shutter, output ro_cy, tx_cy, dly_cy, shut_cy, gap_cy);
   modport seq  (output colour, height, packets, shutter, input ro_cy, tx_cy, dly_cy, shut_cy, gap_cy);
endinterface
`default_nettype wire

// file: design/esq_calc.sv
// Timing calculator: readout, transmission, start delay and safe gap in clock cycles
`timescale 1ns/1ns
`default_nettype none
`include "esq_map.svh"
module esq_calc #(
   parameter int unsigned ROW_CY   = `ESQ_TO_CY(`ESQ_ROW_T),
   parameter int unsigned CMONO_CY = `ESQ_TO_CY(`ESQ_CMONO_T),
   parameter int unsigned CCOL_CY  = `ESQ_TO_CY(`ESQ_CCOL_T),
   parameter int unsigned BUS_CY   = `ESQ_TO_CY(`ESQ_BUS_T)
)(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Timing values
   esq_calc_if.calc  cif
);
   import esq_pkg::*;

   esq_calc_type c_r;
   esq_calc_type c_nxt;

   // Derive readout, transmission and shutter figures from the live settings, start delay and gap from the registered ones
   always_comb begin
      c_nxt = c_r;
      c_nxt.ro_cy = 32'(cif.height) * ROW_CY + (cif.colour ? CCOL_CY : CMONO_CY);
      c_nxt.tx_cy = 32'(cif.packets) * BUS_CY;
      if (c_r.tx_cy > c_r.ro_cy) begin
         c_nxt.dly_cy = BUS_CY;
      end else begin
         c_nxt.dly_cy = c_r.ro_cy - c_r.tx_cy + BUS_CY;
      end
      c_nxt.shut_cy = 32'(cif.shutter) * 32'(`ESQ_CLK_MHZ);
      // Next exposure may end no earlier than this readout finishes
      c_nxt.gap_cy = (c_r.ro_cy > c_r.shut_cy) ? c_r.ro_cy - c_r.shut_cy : 32'h0;
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   assign cif.ro_cy   = c_r.ro_cy;
   assign cif.tx_cy   = c_r.tx_cy;
   assign cif.dly_cy  = c_r.dly_cy;
   assign cif.shut_cy = c_r.shut_cy;
   assign cif.gap_cy  = c_r.gap_cy;
endmodule
`default_nettype wire

// file: design/esq_sequencer.sv
// Exposure sequencer with trigger-safe output, readout timing and AXI4-Lite registers
//
// How it works
// - Exposure first; readout starts only after that exposure has ended.
// - Overlap flagged when frame period <= exposure plus readout time; no mode register.
// - Trigger-safe drops at exposure start, rises at earliest safe next start.
// - Safe rise computed from shutter, region-of-interest height and readout time.
// - Trigger-safe goes to output port 1 by default; routing is programmable.
// - Trigger-safe only produced while external triggering is enabled.
// - Triggers arriving while trigger-safe is low are ignored.
// - Rising or falling trigger edge; programmable or level-controlled exposure.
// - Exposure starts within 5 us (58 us overlapped) of trigger edge.
// - Exposure-active rises 5 to 20 us after exposure starts.
// - Programmable mode exposure lasts exactly the programmed time.
// - Exposure-active falls 30 to 100 us after exposure ends.
// - Transmission starts only when buffer cannot overrun or underrun.
// - Readout time is height times 44.56 us plus sensor constant.
// - Transmission time is packets per frame times 125 us.
// - Start delay 125 us, or readout minus transmission plus 125 us.
// - Exposure-active follows the exposure, rising 5 us after its start and falling 30 us after its end.
// - Polarity 0 selects falling edge, 1 selects rising edge.
`timescale 1ns/1ns
`default_nettype none
`include "esq_map.svh"
module esq_sequencer #(
   parameter int unsigned ROW_CY   = `ESQ_TO_CY(`ESQ_ROW_T),
   parameter int unsigned CMONO_CY = `ESQ_TO_CY(`ESQ_CMONO_T),
   parameter int unsigned CCOL_CY  = `ESQ_TO_CY(`ESQ_CCOL_T),
   parameter int unsigned BUS_CY   = `ESQ_TO_CY(`ESQ_BUS_T),
   parameter int unsigned NPORT    = 4
)(
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write
   input  wire esq_pkg::esq_addr_type awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire esq_pkg::esq_word_type wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // AXI4-Lite read
   input  wire esq_pkg::esq_addr_type araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output esq_pkg::esq_word_type    rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   // Trigger and monitor pins
   input  wire logic                ext_exposure_trigger,
   output logic                     trigger_safe_flag,
   output logic                     exposure_active_out,
   output logic [NPORT-1:0]         out_port,
   // Sensor and transmitter
   output logic                     sensor_exposing,
   output logic                     readout_active,
   output logic                     tx_start,
   output logic                     tx_active
);
   import esq_pkg::*;

   esq_calc_if    cif();
   esq_state_type s_r;
   esq_state_type s_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Register decode, shared by write and read paths
   function automatic esq_reg_type reg_sel(input esq_addr_type a);
      unique case (a)
         `ESQ_CTRL_OFS: reg_sel = REG_CTRL;
         `ESQ_SHUT_OFS: reg_sel = REG_SHUT;
         `ESQ_ROI_OFS:  reg_sel = REG_ROI;
         `ESQ_PKT_OFS:  reg_sel = REG_PKT;
         `ESQ_OSEL_OFS: reg_sel = REG_OSEL;
         `ESQ_STAT_OFS: reg_sel = REG_STAT;
         `ESQ_FCNT_OFS: reg_sel = REG_FCNT;
         default:       reg_sel = REG_NONE;
      endcase
   endfunction

   // Byte-lane merge of write data into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Timing calculator

   assign cif.colour  = s_r.ctrl[`ESQ_CTRL_COL_BIT];
   assign cif.height  = s_r.height;
   assign cif.packets = s_r.packets;
   assign cif.shutter = s_r.shutter;

   esq_calc #(
      .ROW_CY   (ROW_CY),
      .CMONO_CY (CMONO_CY),
      .CCOL_CY  (CCOL_CY),
      .BUS_CY   (BUS_CY)
   ) u_calc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cif     (cif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      logic        en;
      logic        lvl;
      logic        hit;
      logic        start;
      logic        ro_go;
      logic [31:0] wv;
      en    = s_r.ctrl[`ESQ_CTRL_EN_BIT];
      lvl   = 1'b0;
      hit   = 1'b0;
      start = 1'b0;
      ro_go = 1'b0;
      wv    = 32'h0;
      s_nxt = s_r;
      s_nxt.trig_d   = ext_exposure_trigger;
      s_nxt.tx_start = 1'b0;
      // Active trigger level and edge by polarity
      lvl = s_r.ctrl[`ESQ_CTRL_POL_BIT] ? ext_exposure_trigger : !ext_exposure_trigger;
      hit = lvl & (s_r.ctrl[`ESQ_CTRL_POL_BIT] ? !s_r.trig_d : s_r.trig_d);
      // Triggers while not safe start nothing
      start = en & hit & s_r.safe & (s_r.exp_st == EXP_IDLE);

      // Assertion helper counters and the frame period counter used by the overlap flag
      if (s_r.since_start != 16'hffff) s_nxt.since_start = s_r.since_start + 16'h1;
      if (s_r.since_end != 16'hffff) s_nxt.since_end = s_r.since_end + 16'h1;
      s_nxt.since_ro = s_r.since_ro + 32'h1;
      if (s_r.period != 32'hffffffff) s_nxt.period = s_r.period + 32'h1;

      // Exposure sequence
      unique case (s_r.exp_st)
         EXP_IDLE: begin
            if (start) begin
               s_nxt.exp_st      = EXP_ON;
               s_nxt.exp_cnt     = 32'h1;
               s_nxt.safe        = 1'b0;
               s_nxt.gap_run     = 1'b0;
               s_nxt.period      = 32'h0;
               s_nxt.since_start = 16'h0;
               s_nxt.on_run      = 1'b1;
               s_nxt.on_cnt      = 12'h0;
               s_nxt.off_run     = 1'b0;
               // Overlap measured from exposure start to exposure start
               s_nxt.ovl = (s_r.frames != 16'h0) && (s_r.period <= s_r.last_exp + cif.ro_cy);
            end
         end
         EXP_ON: begin
            s_nxt.exp_cnt = s_r.exp_cnt + 32'h1;
            // Shutter is the exact length, or the minimum in level mode
            if (s_r.exp_cnt >= cif.shut_cy && !(s_r.ctrl[`ESQ_CTRL_LVL_BIT] && lvl)) begin
               s_nxt.exp_st    = EXP_IDLE;
               s_nxt.last_exp  = s_r.exp_cnt;
               s_nxt.gap_run   = 1'b1;
               s_nxt.gap_cnt   = cif.gap_cy;
               s_nxt.off_run   = 1'b1;
               s_nxt.off_cnt   = 12'h0;
               s_nxt.since_end = 16'h0;
               if (s_r.ro_busy) s_nxt.ro_pend = 1'b1;
               else ro_go = 1'b1;
            end
         end
      endcase

      // Safe rise after the computed gap
      if (s_r.gap_run) begin
         if (s_r.gap_cnt == 32'h0) begin
            s_nxt.safe    = 1'b1;
            s_nxt.gap_run = 1'b0;
         end else begin
            s_nxt.gap_cnt = s_r.gap_cnt - 32'h1;
         end
      end

      // Readout countdown; a pending frame follows at once
      if (s_r.ro_busy) begin
         if (s_r.ro_cnt <= 32'h1) begin
            s_nxt.ro_busy = 1'b0;
            if (s_r.ro_pend) begin
               s_nxt.ro_pend = 1'b0;
               ro_go = 1'b1;
            end
         end else begin
            s_nxt.ro_cnt = s_r.ro_cnt - 32'h1;
         end
      end
      if (ro_go) begin
         s_nxt.ro_busy  = 1'b1;
         s_nxt.ro_cnt   = cif.ro_cy;
         s_nxt.txd_run  = 1'b1;
         s_nxt.txd_cnt  = cif.dly_cy;
         s_nxt.dly_l    = cif.dly_cy;
         s_nxt.since_ro = 32'h0;
      end

      // Transmission starts after the buffer start delay
      if (s_r.txd_run && !ro_go) begin
         if (s_r.txd_cnt <= 32'h1) begin
            s_nxt.txd_run  = 1'b0;
            s_nxt.tx_start = 1'b1;
            s_nxt.tx_busy  = 1'b1;
            s_nxt.tx_cnt   = cif.tx_cy;
            s_nxt.frames   = s_r.frames + 16'h1;
         end else begin
            s_nxt.txd_cnt = s_r.txd_cnt - 32'h1;
         end
      end
      // Hold the fresh count on the start edge so the frame lasts exactly tx_cy cycles
      if (s_r.tx_busy && !s_nxt.tx_start) begin
         if (s_r.tx_cnt <= 32'h1) s_nxt.tx_busy = 1'b0;
         else s_nxt.tx_cnt = s_r.tx_cnt - 32'h1;
      end

      // Exposure-active delayed rise and fall
      if (s_r.on_run && !start) begin
         s_nxt.on_cnt = s_r.on_cnt + 12'h1;
         if (s_r.on_cnt == 12'(`ESQ_ACT_ON_CY - 1)) begin
            s_nxt.act    = 1'b1;
            s_nxt.on_run = 1'b0;
         end
      end
      if (s_r.off_run && !start && !(s_r.exp_st == EXP_ON && s_nxt.exp_st == EXP_IDLE)) begin
         s_nxt.off_cnt = s_r.off_cnt + 12'h1;
         if (s_r.off_cnt == 12'(`ESQ_ACT_OFF_CY - 1) && !s_r.on_run) begin
            s_nxt.act     = 1'b0;
            s_nxt.off_run = 1'b0;
         end
      end

      // Bus response completion
      if (s_r.bvalid && bready) s_nxt.bvalid = 1'b0;
      if (s_r.rvalid && rready) s_nxt.rvalid = 1'b0;
      // Address and data are taken independently
      if (awvalid && !s_r.aw_v) begin
         s_nxt.aw_v   = 1'b1;
         s_nxt.awaddr = awaddr;
      end
      if (wvalid && !s_r.w_v) begin
         s_nxt.w_v   = 1'b1;
         s_nxt.wdata = wdata;
         s_nxt.wstrb = wstrb;
      end
      // Register write once both halves are held
      if (s_r.aw_v && s_r.w_v && !s_r.bvalid) begin
         s_nxt.aw_v   = 1'b0;
         s_nxt.w_v    = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = `ESQ_RESP_OKAY;
         unique case (reg_sel(s_r.awaddr))
            REG_CTRL: begin
               wv = merge({28'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb);
               s_nxt.ctrl = wv[3:0];
            end
            REG_SHUT: begin
               wv = merge({12'h0, s_r.shutter}, s_r.wdata, s_r.wstrb);
               s_nxt.shutter = wv[19:0];
            end
            REG_ROI: begin
               wv = merge({21'h0, s_r.height}, s_r.wdata, s_r.wstrb);
               s_nxt.height = wv[10:0];
            end
            REG_PKT: begin
               wv = merge({16'h0, s_r.packets}, s_r.wdata, s_r.wstrb);
               s_nxt.packets = wv[15:0];
            end
            REG_OSEL: begin
               wv = merge({28'h0, s_r.osel}, s_r.wdata, s_r.wstrb);
               s_nxt.osel = wv[3:0];
            end
            REG_STAT, REG_FCNT: begin
               s_nxt.bresp = `ESQ_RESP_OKAY;
            end
            REG_NONE: begin
               s_nxt.bresp = `ESQ_RESP_DECERR;
            end
         endcase
      end
      // Register read
      if (arvalid && !s_r.rvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = `ESQ_RESP_OKAY;
         unique case (reg_sel(araddr))
            REG_CTRL: s_nxt.rdata = {28'h0, s_r.ctrl};
            REG_SHUT: s_nxt.rdata = {12'h0, s_r.shutter};
            REG_ROI:  s_nxt.rdata = {21'h0, s_r.height};
            REG_PKT:  s_nxt.rdata = {16'h0, s_r.packets};
            REG_OSEL: s_nxt.rdata = {28'h0, s_r.osel};
            REG_STAT: s_nxt.rdata = {26'h0, s_r.act, s_r.ovl, s_r.tx_busy, s_r.ro_busy,
                                     s_r.exp_st == EXP_ON, s_r.safe};
            REG_FCNT: s_nxt.rdata = {16'h0, s_r.frames};
            REG_NONE: begin
               s_nxt.rdata = 32'h0;
               s_nxt.rresp = `ESQ_RESP_DECERR;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r         <= '0;
         s_r.exp_st  <= EXP_IDLE;
         s_r.safe    <= 1'b1;
         s_r.ctrl    <= `ESQ_CTRL_RST;
         s_r.shutter <= `ESQ_SHUT_RST;
         s_r.height  <= `ESQ_ROI_RST;
         s_r.packets <= `ESQ_PKT_RST;
         s_r.osel    <= `ESQ_OSEL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign awready             = !s_r.aw_v;
   assign wready              = !s_r.w_v;
   assign bvalid              = s_r.bvalid;
   assign bresp               = s_r.bresp;
   assign arready             = !s_r.rvalid;
   assign rvalid              = s_r.rvalid;
   assign rdata               = s_r.rdata;
   assign rresp               = s_r.rresp;
   assign trigger_safe_flag   = s_r.safe & s_r.ctrl[`ESQ_CTRL_EN_BIT];
   assign exposure_active_out = s_r.act;
   assign sensor_exposing     = s_r.exp_st == EXP_ON;
   assign readout_active      = s_r.ro_busy;
   assign tx_start            = s_r.tx_start;
   assign tx_active           = s_r.tx_busy;

   // Physical output port routing
   for (genvar i = 0; i < NPORT; i++) begin : g_port
      assign out_port[i] = (32'(s_r.osel[`ESQ_OSEL_SAFE_LSB +: 2]) == i && trigger_safe_flag) ||
                           (32'(s_r.osel[`ESQ_OSEL_ACT_LSB +: 2]) == i && s_r.act);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   safe_drop_a: assert property ($rose(sensor_exposing) |-> !s_r.safe)
      else $error("trigger-safe still high after exposure start");
   ignore_low_a: assert property (!s_r.safe && s_r.exp_st == EXP_IDLE |=> !$rose(sensor_exposing))
      else $error("exposure started while trigger-safe low");
   fast_start_a: assert property (ext_exposure_trigger && !s_r.trig_d && s_r.ctrl == 4'h3 &&
                                  s_r.safe && !sensor_exposing |=> sensor_exposing)
      else $error("exposure did not start one cycle after rising trigger");
   act_rise_a: assert property ($rose(exposure_active_out) |-> s_r.since_start == 16'(`ESQ_ACT_ON_CY))
      else $error("exposure-active rise delay wrong");
   act_fall_a: assert property ($fell(exposure_active_out) |-> s_r.since_end == 16'(`ESQ_ACT_OFF_CY))
      else $error("exposure-active fall delay wrong");
   exp_len_a: assert property ($fell(sensor_exposing) && !s_r.ctrl[`ESQ_CTRL_LVL_BIT] |->
                               s_r.last_exp == (cif.shut_cy == 32'h0 ? 32'h1 : cif.shut_cy))
      else $error("programmed exposure length not met");
   ro_after_a: assert property ($rose(readout_active) |-> !sensor_exposing)
      else $error("readout began during exposure");
   tx_delay_a: assert property (tx_start |-> s_r.since_ro == (s_r.dly_l == 32'h0 ? 32'h1 : s_r.dly_l))
      else $error("transmission start delay wrong");
   safe_gate_a: assert property (!s_r.ctrl[`ESQ_CTRL_EN_BIT] |-> !trigger_safe_flag && !out_port[1])
      else $error("trigger-safe driven without external triggering");
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");

   ovl_c:   cover property ($rose(s_r.ovl));
   level_c: cover property (s_r.ctrl[`ESQ_CTRL_LVL_BIT] && $fell(sensor_exposing));
   tx_c:    cover property (tx_start);
   skip_c:  cover property (ext_exposure_trigger && !s_r.trig_d && !s_r.safe);
endmodule
`default_nettype wire

// file: verif/esq_trig_src.sv
// Trigger source model facing the sequencer trigger pin
`timescale 1ns/1ns
`default_nettype none
module esq_trig_src (
   // Clock
   input  wire logic aclk,
   // Request and monitor
   input  wire logic go,
   input  wire logic safe,
   // Trigger pin
   output var logic  trig
);
   // Rising edge only while safe; hold the level so no second edge lands mid-capture
   always_ff @(posedge aclk) begin
      trig <= go & (safe | trig);
   end
endmodule
`default_nettype wire

// file: verif/exposure_sequencer_with_trigger_ready_tb.sv
// Self-checking bench of the exposure sequencer
`timescale 1ns/1ns
`default_nettype none
module exposure_sequencer_with_trigger_ready_tb;
   import esq_pkg::*;
   logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
   logic         awready, wready, bvalid, arready, rvalid, trig, safe, act, expo, ro, txs, txa;
   esq_addr_type awaddr, araddr;
   esq_word_type wdata, rdata, rd;
   logic [3:0]   wstrb, out_port;
   logic [1:0]   bresp, rresp, rs;
   logic [41:0]  rows [6];
   int           n_mismatch, tests_run, i, k;
   ////////////////////////////////////////
   // Shortened counts keep the run brief
   esq_sequencer #(.ROW_CY(4), .CMONO_CY(50), .CCOL_CY(60), .BUS_CY(10), .NPORT(4)) u_dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .ext_exposure_trigger(trig), .trigger_safe_flag(safe), .exposure_active_out(act),
      .out_port, .sensor_exposing(expo), .readout_active(ro), .tx_start(txs), .tx_active(txa));
   esq_trig_src u_src (.aclk, .go, .safe, .trig);
   // Clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   ////////////////////////////////////////
   task automatic end_of_test;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic lim(input int c, input int n);
      if (c >= n) begin
         n_mismatch++;
         end_of_test;
      end
   endtask
   task automatic chk(input string n, input esq_word_type e, input esq_word_type g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   // Write: address and data offered together, each released when taken
   task automatic wr(input esq_addr_type a, input esq_word_type d);
      int  j;
      logic ta, tw, tb;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (j = 0; j < 99; j++) begin
         @(negedge aclk); ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; rs = bresp;
         @(posedge aclk); if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0;
         if (tb) begin bready <= 1'b0; break; end
      end
      lim(j, 99);
      @(posedge aclk);
   endtask
   task automatic rdr(input esq_addr_type a);
      int  j;
      logic ta, tr;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (j = 0; j < 99; j++) begin
         @(negedge aclk); ta = arvalid & arready; tr = rvalid; rd = rdata; rs = rresp;
         @(posedge aclk); if (ta) arvalid <= 1'b0;
         if (tr) begin rready <= 1'b0; break; end
      end
      lim(j, 99);
      @(posedge aclk);
   endtask
   ////////////////////////////////////////
   // Main sequence
   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf; go = 1'b0;
      n_mismatch = 0; tests_run = 0;
      rows = '{{8'h00, 32'h3, 2'h0}, {8'h04, 32'h3e8, 2'h0}, {8'h08, 32'h410, 2'h0},
               {8'h0c, 32'h40, 2'h0}, {8'h10, 32'h1, 2'h0}, {8'h1c, 32'h0, 2'h3}};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk("safe", 32'h1, safe);
      chk("port", 32'h2, out_port);
      @(posedge aclk);
      for (k = 0; k < 6; k++) begin
         rdr(rows[k][41:34]);
         chk("rdata", rows[k][33:2], rd);
         chk("rresp", rows[k][1:0], rs);
      end
      wr(8'h1c, 32'h0);
      chk("bresp", 32'h3, rs);
      wr(8'h04, 32'h8);
      wr(8'h08, 32'h5);
      wr(8'h0c, 32'h4);
      go <= 1'b1;
      for (i = 0; i < 99 && expo !== 1'b1; i++) @(negedge aclk);
      lim(i, 99);
      chk("safe low", 32'h0, safe);
      for (i = 0; i < 2000 && expo === 1'b1; i++) @(negedge aclk);
      chk("exposure", 32'd1000, i);
      chk("readout", 32'h1, ro);
      for (i = 0; i < 200 && txs !== 1'b1; i++) @(negedge aclk);
      chk("tx delay", 32'd40, i);
      for (i = 0; i < 99 && txa === 1'b1; i++) @(negedge aclk);
      chk("tx time", 32'd40, i);
      chk("safe high", 32'h1, safe);
      chk("active", 32'h1, act);
      @(posedge aclk);
      go <= 1'b0;
      wr(8'h00, 32'h2);
      @(negedge aclk);
      chk("disabled", 32'h0, safe);
      chk("port", 32'h1, out_port);
      @(posedge aclk);
      wr(8'h00, 32'h1);
      go <= 1'b1;
      repeat (4) @(negedge aclk);
      chk("rise ign", 32'h0, expo);
      @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(negedge aclk);
      chk("fall trig", 32'h1, expo);
      // Frame period just above exposure plus readout: not overlapped, exposing, active still high
      @(posedge aclk);
      rdr(8'h14);
      chk("status", 32'h22, rd);
      end_of_test;
   end
endmodule
`default_nettype wire
